// ==== design/ratu_map.svh ====
// Offsets, field positions and fixed figures of the address translation unit
`ifndef RATU_MAP_SVH
`define RATU_MAP_SVH
`define VA_W 32
`define ASID_W 8
`define UTLB_ENTRIES 4
`define PG_SH_4K 12
`define PG_SH_1K 10
`define ODD_TOP 28
`define SEG_HI 31
`define SEG_LO 29
`define SEG_CACHED 3'h4
`define SEG_UNCACHED 3'h5
`define KSEG_PA_MASK 32'h1fff_ffff
`endif

// ==== design/ratu_pkg.sv ====
// Types shared by the address translation unit files
package ratu_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_JOINT = 4'h2,
    ST_FILL  = 4'h4,
    ST_FAULT = 4'h8
  } walk_state_t;

  typedef struct packed {
    logic v;
    logic d;
    logic ri;
    logic xi;
  } page_attr_t;
endpackage

// ==== design/joint_translation_buffer_data_if.sv ====
// Carrier between the lookup logic and the paired page data store
`timescale 1ns/1ps
interface joint_translation_buffer_data_if #(
  parameter int IDX_W = 4,
  parameter int W = 48
);
  logic we;
  logic [IDX_W-1:0] widx;
  logic [W-1:0] wdata;
  logic [IDX_W-1:0] ridx;
  logic [W-1:0] rdata;
  modport ctrl (output we, output widx, output wdata, output ridx,
                input rdata);
  modport mem (input we, input widx, input wdata, input ridx,
               output rdata);
endinterface

// ==== design/joint_translation_buffer_pair_mem.sv ====
// Even/odd page data store of the joint buffer, registered read
`timescale 1ns/1ps
module joint_translation_buffer_pair_mem #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4,
  parameter int W = 48
)(
  input wire logic i_core_clk,
  joint_translation_buffer_data_if.mem mem_port
);
  logic [W-1:0] store_r [DEPTH];
  logic [W-1:0] rdata_r;

  if (DEPTH > (1 << IDX_W)) begin : g_bad_depth
    $error("joint_translation_buffer_pair_mem: index too narrow for depth");
  end

  // No reset on the array: entries count only once their tag is valid
  always_ff @(posedge i_core_clk) begin
    if (mem_port.we) begin
      store_r[mem_port.widx] <= mem_port.wdata;
    end
    rdata_r <= store_r[mem_port.ridx];
  end

  assign mem_port.rdata = rdata_r;
endmodule

// ==== design/root_address_translation_unit.sv ====
// Root context address translation and protection unit
//
// Contract
// - Buffer build: own joint buffer of 16 or 32 pairs, separate fetch and data micros.
// - Buffer-build pages block read, execute and write violations.
// - Protection build: 8/16/32 pairs, fixed map of kernel segments.
// - Protection build blocks read, execute and write violations.
// - Fetch: micro buffer, then joint buffer, else refill fault.
// - Data: micro buffer, then joint buffer, else refill fault.
// - Joint compare of upper address bits and id against all tags.
// - Sixteen pairs map 32 pages of up to 256 MB in a 4 GB space.
// - The minimum page is 4 KB, or 1 KB as a build option.
// - A tag owns even and odd halves, picked by the top uncompared bit.
// - Compare bits and half select follow the matched page size.
// - The instruction micro buffer holds only minimum-size pages.
// - Fetch micro miss: joint try next cycle, self refill, 2 cycles.
// - The data micro buffer holds only minimum-size pages.
// - Joint search beside the data micro buffer; 1-cycle penalty.
`timescale 1ns/1ps
`include "ratu_map.svh"
module root_address_translation_unit
  import ratu_pkg::*;
#(
  parameter int BUILD_TLB = 1,
  parameter int JOINT_ENTRIES = 16,
  parameter int MIN_PAGE_1K = 0,
  localparam int PG_SH = (MIN_PAGE_1K != 0) ? `PG_SH_1K : `PG_SH_4K,
  localparam int VPN2_W = `VA_W - PG_SH - 1,
  localparam int MASK_W = `ODD_TOP - PG_SH,
  localparam int PFN_W = `VA_W - PG_SH,
  localparam int IDX_W = $clog2(JOINT_ENTRIES),
  localparam int DW = PFN_W + 4
)(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [`ASID_W-1:0] i_asid,
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_index,
  input wire logic [VPN2_W-1:0] i_wr_vpn2,
  input wire logic [MASK_W-1:0] i_wr_mask,
  input wire logic [`ASID_W-1:0] i_wr_asid,
  input wire logic i_wr_global,
  input wire logic [PFN_W-1:0] i_wr_even_pfn,
  input wire logic [3:0] i_wr_even_attr,
  input wire logic [PFN_W-1:0] i_wr_odd_pfn,
  input wire logic [3:0] i_wr_odd_attr,
  input wire logic i_if_req,
  input wire logic [`VA_W-1:0] i_if_va,
  input wire logic i_ls_req,
  input wire logic i_ls_store,
  input wire logic [`VA_W-1:0] i_ls_va,
  input wire logic i_exc_taken,
  output logic o_if_valid,
  output logic [`VA_W-1:0] o_if_pa,
  output logic o_if_blocked,
  output logic o_if_refill,
  output logic [`VA_W-1:0] o_if_fault_va,
  output logic o_ls_valid,
  output logic [`VA_W-1:0] o_ls_pa,
  output logic o_ls_blocked,
  output logic o_ls_refill,
  output logic [`VA_W-1:0] o_ls_fault_va
);
  localparam int UE = `UTLB_ENTRIES;

  if (!(JOINT_ENTRIES == 16 || JOINT_ENTRIES == 32 ||
        (BUILD_TLB == 0 && JOINT_ENTRIES == 8))) begin : g_bad_size
    $error("root_address_translation_unit: unsupported entry count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Joint buffer tags
  logic [JOINT_ENTRIES-1:0] tag_vld_r;
  logic [JOINT_ENTRIES-1:0] tag_g_r;
  logic [VPN2_W-1:0] tag_vpn2_r [JOINT_ENTRIES];
  logic [MASK_W-1:0] tag_mask_r [JOINT_ENTRIES];
  logic [`ASID_W-1:0] tag_asid_r [JOINT_ENTRIES];

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tag_vld_r <= '0;
      tag_g_r <= '0;
      for (int e = 0; e < JOINT_ENTRIES; e++) begin
        tag_vpn2_r[e] <= '0;
        tag_mask_r[e] <= '0;
        tag_asid_r[e] <= '0;
      end
    end else if (i_wr_en) begin
      tag_vld_r[i_wr_index] <= 1'b1;
      tag_g_r[i_wr_index] <= i_wr_global;
      tag_vpn2_r[i_wr_index] <= i_wr_vpn2;
      tag_mask_r[i_wr_index] <= i_wr_mask;
      tag_asid_r[i_wr_index] <= i_wr_asid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared joint lookup port, data side wins a clash
  walk_state_t st_r [2];
  logic [`VA_W-1:0] va_r [2];
  logic [1:0] store_r;
  logic [1:0] u_hit;
  logic [1:0] kseg;
  logic [1:0] req;
  logic [`VA_W-1:0] va_in [2];
  logic [JOINT_ENTRIES-1:0] j_hit;
  logic [IDX_W-1:0] j_idx;
  logic [MASK_W-1:0] j_mask;
  logic j_g;

  assign req = {i_ls_req, i_if_req};
  assign va_in[0] = i_if_va;
  assign va_in[1] = i_ls_va;

  wire d_look = st_r[1] == ST_IDLE && req[1] && !kseg[1] && !u_hit[1];
  wire i_look = st_r[0] == ST_JOINT && !d_look;
  wire [`VA_W-1:0] j_va = d_look ? i_ls_va : va_r[0];
  wire [PFN_W-1:0] j_vmin = j_va[`VA_W-1:PG_SH];
  wire j_any = |j_hit;

  for (genvar e = 0; e < JOINT_ENTRIES; e++) begin : g_cmp
    wire [VPN2_W-1:0] care =
      ~{{(VPN2_W - MASK_W){1'b0}}, tag_mask_r[e]};
    wire vpn_eq = ((j_va[`VA_W-1:PG_SH+1] ^ tag_vpn2_r[e]) & care) == '0;
    assign j_hit[e] = tag_vld_r[e] && vpn_eq &&
      (tag_g_r[e] || tag_asid_r[e] == i_asid);
  end

  always_comb begin
    j_idx = '0;
    j_mask = '0;
    j_g = 1'b0;
    for (int e = 0; e < JOINT_ENTRIES; e++) begin
      if (j_hit[e]) begin
        j_idx = IDX_W'(e);
        j_mask = tag_mask_r[e];
        j_g = tag_g_r[e];
      end
    end
  end

  // The top uncompared page-number bit picks the half of the pair
  wire [MASK_W:0] odd_oh = {j_mask, 1'b1} & ~{1'b0, j_mask};
  wire j_odd = |(j_vmin[MASK_W:0] & odd_oh);
  wire [PFN_W-1:0] j_off = {{(PFN_W - MASK_W){1'b0}}, j_mask};

  logic [PFN_W-1:0] ctx_vmin_r;
  logic [PFN_W-1:0] ctx_off_r;
  logic ctx_odd_r;
  logic ctx_g_r;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctx_vmin_r <= '0;
      ctx_off_r <= '0;
      ctx_odd_r <= 1'b0;
      ctx_g_r <= 1'b0;
    end else if (d_look || i_look) begin
      ctx_vmin_r <= j_vmin;
      ctx_off_r <= j_off;
      ctx_odd_r <= j_odd;
      ctx_g_r <= j_g;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Paired page data, read one cycle after the compare
  joint_translation_buffer_data_if #(.IDX_W(IDX_W), .W(2 * DW)) jd_if ();

  assign jd_if.we = i_wr_en;
  assign jd_if.widx = i_wr_index;
  assign jd_if.wdata = {i_wr_odd_pfn, i_wr_odd_attr,
                        i_wr_even_pfn, i_wr_even_attr};
  assign jd_if.ridx = j_idx;

  joint_translation_buffer_pair_mem #(.DEPTH(JOINT_ENTRIES), .IDX_W(IDX_W), .W(2 * DW)) u_mem (
    .i_core_clk(i_core_clk),
    .mem_port(jd_if)
  );

  wire [DW-1:0] rd_half = ctx_odd_r ? jd_if.rdata[2*DW-1:DW] :
                                      jd_if.rdata[DW-1:0];
  wire [PFN_W-1:0] rd_pfn = rd_half[DW-1:4];
  page_attr_t rd_attr;
  assign rd_attr = page_attr_t'(rd_half[3:0]);
  // Protection build keeps the identity map and only validates it
  wire [PFN_W-1:0] fill_pfn = (BUILD_TLB != 0) ?
    ((rd_pfn & ~ctx_off_r) | (ctx_vmin_r & ctx_off_r)) : ctx_vmin_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per path: micro buffer, walk and result registers (0 fetch, 1 data)
  logic [1:0] out_valid_r;
  logic [1:0] out_blk_r;
  logic [1:0] out_refill_r;
  logic [`VA_W-1:0] out_pa_r [2];
  logic [`VA_W-1:0] out_fva_r [2];

  for (genvar p = 0; p < 2; p++) begin : g_path
    logic [UE-1:0] u_vld_r;
    logic [UE-1:0] u_g_r;
    logic [PFN_W-1:0] u_vmin_r [UE];
    logic [PFN_W-1:0] u_pfn_r [UE];
    logic [`ASID_W-1:0] u_asid_r [UE];
    page_attr_t u_attr_r [UE];
    logic [1:0] u_ptr_r;
    logic [UE-1:0] u_m;
    logic [PFN_W-1:0] u_pfn;
    page_attr_t u_attr;
    walk_state_t st_nxt;

    wire [PFN_W-1:0] vmin = va_in[p][`VA_W-1:PG_SH];
    wire [2:0] seg = va_in[p][`SEG_HI:`SEG_LO];
    wire st_in = (p == 1) ? i_ls_store : 1'b0;
    assign kseg[p] = seg == `SEG_CACHED || seg == `SEG_UNCACHED;

    for (genvar u = 0; u < UE; u++) begin : g_ent
      assign u_m[u] = u_vld_r[u] && u_vmin_r[u] == vmin &&
        (u_g_r[u] || u_asid_r[u] == i_asid);
    end
    assign u_hit[p] = |u_m;

    always_comb begin
      u_pfn = '0;
      u_attr = '0;
      for (int u = 0; u < UE; u++) begin
        if (u_m[u]) begin
          u_pfn = u_pfn_r[u];
          u_attr = u_attr_r[u];
        end
      end
    end

    // Fetch checks execute-inhibit, data checks read-inhibit or write
    wire hit_blk = (p == 0) ? u_attr.xi :
      (st_in ? !u_attr.d : u_attr.ri);
    wire fill_blk = (p == 0) ? rd_attr.xi :
      (store_r[p] ? !rd_attr.d : rd_attr.ri);
    wire fill_ok = st_r[p] == ST_FILL && rd_attr.v;

    always_comb begin
      st_nxt = st_r[p];
      case (st_r[p])
        ST_IDLE: begin
          if (req[p] && !kseg[p] && !u_hit[p]) begin
            if (p == 0) begin
              st_nxt = ST_JOINT;
            end else begin
              st_nxt = j_any ? ST_FILL : ST_FAULT;
            end
          end
        end
        ST_JOINT: begin
          if (i_look) begin
            st_nxt = j_any ? ST_FILL : ST_FAULT;
          end
        end
        ST_FILL: st_nxt = rd_attr.v ? ST_IDLE : ST_FAULT;
        ST_FAULT: begin
          if (i_exc_taken) begin
            st_nxt = ST_IDLE;
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        u_vld_r <= '0;
        u_ptr_r <= '0;
        u_g_r <= '0;
        for (int u = 0; u < UE; u++) begin
          u_vmin_r[u] <= '0;
          u_pfn_r[u] <= '0;
          u_asid_r[u] <= '0;
          u_attr_r[u] <= '0;
        end
      end else if (i_wr_en) begin
        u_vld_r <= '0;
      end else if (fill_ok) begin
        u_vld_r[u_ptr_r] <= 1'b1;
        u_vmin_r[u_ptr_r] <= ctx_vmin_r;
        u_pfn_r[u_ptr_r] <= fill_pfn;
        u_asid_r[u_ptr_r] <= i_asid;
        u_g_r[u_ptr_r] <= ctx_g_r;
        u_attr_r[u_ptr_r] <= rd_attr;
        u_ptr_r <= u_ptr_r + 2'h1;
      end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        st_r[p] <= ST_IDLE;
        va_r[p] <= '0;
        store_r[p] <= 1'b0;
        out_valid_r[p] <= 1'b0;
        out_blk_r[p] <= 1'b0;
        out_refill_r[p] <= 1'b0;
        out_pa_r[p] <= '0;
        out_fva_r[p] <= '0;
      end else begin
        st_r[p] <= st_nxt;
        out_refill_r[p] <= st_nxt == ST_FAULT;
        out_valid_r[p] <= 1'b0;
        if (st_nxt == ST_FAULT && st_r[p] != ST_FAULT) begin
          out_fva_r[p] <= (st_r[p] == ST_IDLE) ? va_in[p] : va_r[p];
        end
        if (st_r[p] == ST_IDLE && req[p]) begin
          va_r[p] <= va_in[p];
          store_r[p] <= st_in;
          if (kseg[p]) begin
            out_valid_r[p] <= 1'b1;
            out_blk_r[p] <= 1'b0;
            out_pa_r[p] <= va_in[p] & `KSEG_PA_MASK;
          end else if (u_hit[p]) begin
            out_valid_r[p] <= 1'b1;
            out_blk_r[p] <= hit_blk;
            out_pa_r[p] <= {u_pfn, va_in[p][PG_SH-1:0]};
          end
        end else if (fill_ok) begin
          out_valid_r[p] <= 1'b1;
          out_blk_r[p] <= fill_blk;
          out_pa_r[p] <= {fill_pfn, va_r[p][PG_SH-1:0]};
        end
      end
    end
  end

  assign o_if_valid = out_valid_r[0];
  assign o_if_pa = out_pa_r[0];
  assign o_if_blocked = out_blk_r[0];
  assign o_if_refill = out_refill_r[0];
  assign o_if_fault_va = out_fva_r[0];
  assign o_ls_valid = out_valid_r[1];
  assign o_ls_pa = out_pa_r[1];
  assign o_ls_blocked = out_blk_r[1];
  assign o_ls_refill = out_refill_r[1];
  assign o_ls_fault_va = out_fva_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  AST_IMISS_PENALTY: assert property (
    st_r[0] == ST_JOINT && i_look && j_any |=>
      st_r[0] == ST_FILL ##1 (o_if_valid || o_if_refill))
    else $error("fetch refill from joint buffer missed its cycle");
  AST_DMISS_PENALTY: assert property (
    d_look && j_any |-> ##2 (o_ls_valid || o_ls_refill))
    else $error("data refill from joint buffer missed its cycle");
  AST_IHIT_NEXT: assert property (
    st_r[0] == ST_IDLE && i_if_req && u_hit[0] |=> o_if_valid)
    else $error("fetch micro hit gave no result next cycle");
  AST_DREFILL: assert property (
    d_look && !j_any |=> o_ls_refill && o_ls_fault_va == $past(i_ls_va))
    else $error("data joint miss raised no refill");
  AST_REFILL_HELD: assert property (
    o_if_refill && !i_exc_taken |=> o_if_refill && $stable(o_if_fault_va))
    else $error("fetch refill dropped before it was taken");
  AST_NO_DATA_IN_FAULT: assert property (
    o_ls_refill |-> !o_ls_valid)
    else $error("data result given during refill");
  AST_KSEG_MAP: assert property (
    st_r[1] == ST_IDLE && i_ls_req && kseg[1] |=> o_ls_valid &&
      !o_ls_blocked && o_ls_pa == ($past(i_ls_va) & `KSEG_PA_MASK))
    else $error("kernel segment not fixed mapped");
  AST_WRITE_PROT: assert property (
    st_r[1] == ST_FILL && store_r[1] && rd_attr.v && !rd_attr.d |=>
      o_ls_valid && o_ls_blocked)
    else $error("store to protected page not blocked");
  AST_EXEC_INH: assert property (
    st_r[0] == ST_FILL && rd_attr.v && rd_attr.xi |=> o_if_blocked)
    else $error("fetch from execute-inhibited page not blocked");

  COV_IMISS: cover property (
    st_r[0] == ST_JOINT ##1 st_r[0] == ST_FILL ##1 o_if_valid);
  COV_DMISS: cover property (d_look && j_any ##2 o_ls_valid);
  COV_REFILL: cover property (o_ls_refill ##[1:4] !o_ls_refill);
endmodule

// ==== test/pipe_stage_model.sv ====
// Fetch and load/store stage model that drives the translation unit
`timescale 1ns/1ps
module pipe_stage_model (
  input wire logic i_core_clk,
  output logic o_if_req,
  output logic [31:0] o_if_va,
  output logic o_ls_req,
  output logic o_ls_store,
  output logic [31:0] o_ls_va,
  output logic o_exc_taken,
  input wire logic i_if_valid,
  input wire logic [31:0] i_if_pa,
  input wire logic i_if_blocked,
  input wire logic i_if_refill,
  input wire logic [31:0] i_if_fault_va,
  input wire logic i_ls_valid,
  input wire logic [31:0] i_ls_pa,
  input wire logic i_ls_blocked,
  input wire logic i_ls_refill,
  input wire logic [31:0] i_ls_fault_va
);
  initial begin
    o_if_req = 1'b0;
    o_if_va = 32'h0;
    o_ls_req = 1'b0;
    o_ls_store = 1'b0;
    o_ls_va = 32'h0;
    o_exc_taken = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Kind 0 fetches, 1 loads, 2 stores; lat stays 99 if nothing answers
  task automatic access(input logic [1:0] kind, input logic [31:0] va,
    output logic [31:0] pa, output logic blk, output logic rf,
    output logic [31:0] fva, output int lat);
    logic f;
    f = (kind == 2'h0);
    lat = 99;
    @(posedge i_core_clk);
    if (f) begin
      o_if_req <= 1'b1;
      o_if_va <= va;
    end else begin
      o_ls_req <= 1'b1;
      o_ls_store <= kind[1];
      o_ls_va <= va;
    end
    @(posedge i_core_clk);
    o_if_req <= 1'b0;
    o_ls_req <= 1'b0;
    // A released address must not look like a still-valid request
    if (f) o_if_va <= ~va;
    else o_ls_va <= ~va;
    for (int n = 1; n <= 16 && lat == 99; n++) begin
      @(posedge i_core_clk);
      pa = f ? i_if_pa : i_ls_pa;
      blk = f ? i_if_blocked : i_ls_blocked;
      rf = f ? i_if_refill : i_ls_refill;
      fva = f ? i_if_fault_va : i_ls_fault_va;
      if ((f ? i_if_valid : i_ls_valid) === 1'b1 || rf === 1'b1) lat = n;
    end
  endtask

  task automatic take_exc();
    @(posedge i_core_clk);
    o_exc_taken <= 1'b1;
    @(posedge i_core_clk);
    o_exc_taken <= 1'b0;
  endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench of the root address translation unit
`timescale 1ns/1ps
module tb;
  localparam logic [1:0] FE = 2'h0;
  localparam logic [1:0] LD = 2'h1;
  localparam logic [1:0] ST = 2'h2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] asid = 8'h0;
  logic wr_en = 1'b0;
  logic [3:0] wr_index = 4'h0;
  logic [18:0] wr_vpn2 = 19'h0;
  logic [15:0] wr_mask = 16'h0;
  logic [7:0] wr_asid = 8'h0;
  logic wr_global = 1'b0;
  logic [19:0] wr_even_pfn = 20'h0;
  logic [3:0] wr_even_attr = 4'h0;
  logic [19:0] wr_odd_pfn = 20'h0;
  logic [3:0] wr_odd_attr = 4'h0;
  logic if_req, ls_req, ls_store, exc_taken, if_valid, if_blocked;
  logic if_refill, ls_valid, ls_blocked, ls_refill;
  logic [31:0] if_va, ls_va, if_pa, if_fault_va, ls_pa, ls_fault_va;
  logic [31:0] pu_if_pa, pu_ls_pa;
  logic pu_if_blk, pu_ls_blk;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  root_address_translation_unit i_dut (
    .i_core_clk(clk), .i_rstn(rst_n), .i_asid(asid), .i_wr_en(wr_en),
    .i_wr_index(wr_index), .i_wr_vpn2(wr_vpn2), .i_wr_mask(wr_mask),
    .i_wr_asid(wr_asid), .i_wr_global(wr_global),
    .i_wr_even_pfn(wr_even_pfn), .i_wr_even_attr(wr_even_attr),
    .i_wr_odd_pfn(wr_odd_pfn), .i_wr_odd_attr(wr_odd_attr),
    .i_if_req(if_req), .i_if_va(if_va), .i_ls_req(ls_req),
    .i_ls_store(ls_store), .i_ls_va(ls_va), .i_exc_taken(exc_taken),
    .o_if_valid(if_valid), .o_if_pa(if_pa), .o_if_blocked(if_blocked),
    .o_if_refill(if_refill), .o_if_fault_va(if_fault_va),
    .o_ls_valid(ls_valid), .o_ls_pa(ls_pa), .o_ls_blocked(ls_blocked),
    .o_ls_refill(ls_refill), .o_ls_fault_va(ls_fault_va));

  pipe_stage_model i_pipe (
    .i_core_clk(clk), .o_if_req(if_req), .o_if_va(if_va),
    .o_ls_req(ls_req), .o_ls_store(ls_store), .o_ls_va(ls_va),
    .o_exc_taken(exc_taken), .i_if_valid(if_valid), .i_if_pa(if_pa),
    .i_if_blocked(if_blocked), .i_if_refill(if_refill),
    .i_if_fault_va(if_fault_va), .i_ls_valid(ls_valid), .i_ls_pa(ls_pa),
    .i_ls_blocked(ls_blocked), .i_ls_refill(ls_refill),
    .i_ls_fault_va(ls_fault_va));

  // Protection build on the same stimulus walks in lockstep
  root_address_translation_unit #(.BUILD_TLB(0)) i_dut_pu (
    .i_core_clk(clk), .i_rstn(rst_n), .i_asid(asid), .i_wr_en(wr_en),
    .i_wr_index(wr_index), .i_wr_vpn2(wr_vpn2), .i_wr_mask(wr_mask),
    .i_wr_asid(wr_asid), .i_wr_global(wr_global),
    .i_wr_even_pfn(wr_even_pfn), .i_wr_even_attr(wr_even_attr),
    .i_wr_odd_pfn(wr_odd_pfn), .i_wr_odd_attr(wr_odd_attr),
    .i_if_req(if_req), .i_if_va(if_va), .i_ls_req(ls_req),
    .i_ls_store(ls_store), .i_ls_va(ls_va), .i_exc_taken(exc_taken),
    .o_if_valid(), .o_if_pa(pu_if_pa), .o_if_blocked(pu_if_blk),
    .o_if_refill(), .o_if_fault_va(),
    .o_ls_valid(), .o_ls_pa(pu_ls_pa), .o_ls_blocked(pu_ls_blk),
    .o_ls_refill(), .o_ls_fault_va());

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [18:0] vpn2,
    input logic [15:0] mask, input logic [7:0] id, input logic g,
    input logic [19:0] ep, input logic [3:0] ea, input logic [19:0] op,
    input logic [3:0] oa);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_index <= idx;
    wr_vpn2 <= vpn2;
    wr_mask <= mask;
    wr_asid <= id;
    wr_global <= g;
    wr_even_pfn <= ep;
    wr_even_attr <= ea;
    wr_odd_pfn <= op;
    wr_odd_attr <= oa;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Latency 0 skips the latency compare where a micro fill is not certain
  task automatic hit(input logic [1:0] k, input logic [31:0] va,
    input int lat, input logic [31:0] pa, input logic blk);
    logic [31:0] p, f, pu_exp;
    logic b, r;
    int n;
    i_pipe.access(k, va, p, b, r, f, n);
    if (lat != 0) check(n, lat);
    if (blk == 1'b0) check(p, pa);
    check({r, b}, {1'b0, blk});
    // Protection build: identity outside the kernel segments
    pu_exp = (va[31:30] == 2'h2) ? (va & 32'h1fff_ffff) : va;
    if (blk == 1'b0)
      check((k == FE) ? pu_if_pa : pu_ls_pa, pu_exp);
    check((k == FE) ? pu_if_blk : pu_ls_blk, blk);
  endtask

  task automatic miss(input logic [1:0] k, input logic [31:0] va,
    input int lat);
    logic [31:0] p, f;
    logic b, r;
    int n;
    i_pipe.access(k, va, p, b, r, f, n);
    check(n, lat);
    check(r, 1'b1);
    check(f, va);
    i_pipe.access(k, ~va, p, b, r, f, n);
    check(f, va);
    i_pipe.take_exc();
    @(posedge clk);
    check({if_refill, ls_refill}, 2'b00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_kseg();
    hit(FE, 32'h8123_4567, 1, 32'h0123_4567, 1'b0);
    hit(ST, 32'ha0ff_0008, 1, 32'h00ff_0008, 1'b0);
    hit(LD, 32'hbfff_fffc, 1, 32'h1fff_fffc, 1'b0);
  endtask

  task automatic t_pair();
    wr(4'h0, 19'h200, 16'h0, 8'h01, 1'b1, 20'h12345, 4'hc, 20'h6789a, 4'hc);
    hit(FE, 32'h0040_0010, 3, 32'h1234_5010, 1'b0);
    hit(FE, 32'h0040_0ffc, 1, 32'h1234_5ffc, 1'b0);
    hit(LD, 32'h0040_1020, 2, 32'h6789_a020, 1'b0);
    hit(ST, 32'h0040_1024, 1, 32'h6789_a024, 1'b0);
  endtask

  // Top entry holds 256 MB pages; a second pair uses 16 KB pages
  task automatic t_size();
    wr(4'hf, 19'h10000, 16'hffff, 8'h0, 1'b1, 20'h50000, 4'hc, 20'hf0000,
       4'hc);
    wr(4'h5, 19'h1000, 16'h3, 8'h0, 1'b1, 20'h30000, 4'hc, 20'h40000, 4'hc);
    hit(FE, 32'h3abc_def0, 3, 32'hfabc_def0, 1'b0);
    hit(FE, 32'h3abc_e000, 3, 32'hfabc_e000, 1'b0);
    hit(FE, 32'h3abc_d004, 1, 32'hfabc_d004, 1'b0);
    hit(LD, 32'h2111_1000, 2, 32'h5111_1000, 1'b0);
    hit(FE, 32'h0200_2abc, 3, 32'h3000_2abc, 1'b0);
    hit(LD, 32'h0200_5123, 2, 32'h4000_1123, 1'b0);
  endtask

  task automatic t_attr();
    wr(4'h3, 19'h800, 16'h0, 8'h0, 1'b1, 20'h0aaaa, 4'hb, 20'h0bbbb, 4'hc);
    hit(FE, 32'h0100_0000, 3, 32'h0, 1'b1);
    hit(ST, 32'h0100_0004, 2, 32'h0, 1'b1);
    hit(LD, 32'h0100_0008, 1, 32'h0, 1'b1);
    hit(ST, 32'h0100_000c, 1, 32'h0, 1'b1);
    hit(ST, 32'h0100_1000, 2, 32'h0bbb_b000, 1'b0);
    hit(LD, 32'h0100_1004, 1, 32'h0bbb_b004, 1'b0);
    hit(FE, 32'h0100_1008, 3, 32'h0bbb_b008, 1'b0);
  endtask

  task automatic t_asid();
    wr(4'h2, 19'h400, 16'h0, 8'h05, 1'b0, 20'h0cccc, 4'hc, 20'h0dddd, 4'hc);
    @(posedge clk);
    asid <= 8'h06;
    miss(LD, 32'h0080_0040, 1);
    @(posedge clk);
    asid <= 8'h05;
    hit(LD, 32'h0080_0040, 2, 32'h0ccc_c040, 1'b0);
    @(posedge clk);
    asid <= 8'h06;
    miss(LD, 32'h0080_0044, 1);
  endtask

  // An invalid half faults like an absent pair
  task automatic t_refill();
    miss(FE, 32'h0600_0000, 2);
    wr(4'h4, 19'h3800, 16'h0, 8'h0, 1'b1, 20'h1, 4'h0, 20'h2, 4'hc);
    miss(FE, 32'h0700_0000, 3);
    miss(LD, 32'h0700_0010, 2);
  endtask

  // Rewriting an entry must not leave a stale micro translation behind
  task automatic t_flush();
    wr(4'h0, 19'h200, 16'h0, 8'h01, 1'b1, 20'h22222, 4'hc, 20'h6789a, 4'hc);
    hit(FE, 32'h0040_0010, 3, 32'h2222_2010, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_kseg();
    t_pair();
    t_size();
    t_attr();
    t_asid();
    t_refill();
    t_flush();
    results();
  end
endmodule
